// ==== rtl/ansr_pkg.sv ====
// Constants, types and helpers for the master/slave negotiation block.
// Assumes a single 100 MHz clock and AXI4-Lite register access.
// How it works
// (RQ1) An unconnected role strap reads low, so the device advertises preferred slave.
// (RQ2) Force bit 12 of register 0x0202 marks the advertised role as preferred (0) or forced (1).
// (RQ3) Master bit 4 of register 0x0203 advertises slave (0) or master (1).
// (RQ4) Partner force and master flags are captured into 0x0205 bit 12 and 0x0206 bit 4.
// (RQ5) Both preferred with the same role settles the roles by a random bit.
// (RQ6) A single forced end gets its role and the other end the opposite one.
// (RQ7) Equal force marks with different roles give each end its own role.
// (RQ8) Both forced with the same role is a configuration fault and keeps the link down.
// (RQ9) The outcome sits in bits 6:5 of 0x8001, valid once negotiation is complete.
// (RQ10) Bit 0 of 0x8001 sets once the exchange has finished without a configuration fault.
// (RQ11) Bit 5 of 0x0201 is set only while negotiation is done and the link is up.
// (RQ12) Link status bit 2 of 0x0201 latches low until it is read.
// (RQ13) A dropped link restarts negotiation without software.
// (RQ14) Writing one to bit 9 of 0x0200 restarts negotiation.
// (RQ15) Software should prefer slave or master and force master only when it must.
// (RQ16) The outcome codes are fixed and distinct, and zero when no result exists.
// (RQ17) The restart bit clears itself once the restart is taken up.
package ansr_pkg;
   localparam int ADDR_W = 18;
   localparam int DATA_W = 32;
   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_CONTROL = 16'h0200;
   localparam logic [15:0] IDX_STATUS = 16'h0201;
   localparam logic [15:0] IDX_LOC_FORCE = 16'h0202;
   localparam logic [15:0] IDX_LOC_ROLE = 16'h0203;
   localparam logic [15:0] IDX_PART_FORCE = 16'h0205;
   localparam logic [15:0] IDX_PART_ROLE = 16'h0206;
   localparam logic [15:0] IDX_RESULT = 16'h8001;
   localparam int BIT_RESTART = 9;
   localparam int BIT_FORCE = 12;
   localparam int BIT_MASTER = 4;
   localparam int BIT_DONE_UP = 5;
   localparam int BIT_LINK_LATCHED = 2;
   localparam int BIT_EXCH_DONE = 0;
   localparam int RES_LSB = 5;
   localparam int RES_MSB = 6;
   localparam int LANE_LO = 0;
   localparam int LANE_HI = 1;
   localparam logic [1:0] RES_NONE = 2'h0;
   localparam logic [1:0] RES_SLAVE = 2'h1;
   localparam logic [1:0] RES_MASTER = 2'h2;
   localparam logic [1:0] RES_FAULT = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] STRAP_SETTLE = 2'h2;
   localparam logic [15:0] LFSR_SEED = 16'hace1;

   typedef enum logic [2:0] {
      AN_IDLE, AN_START, AN_WAIT_PAGE, AN_LINK_WAIT, AN_LINK_UP, AN_FAULT
   } ansr_fsm_t;

   typedef struct packed {
      logic force_flag;
      logic master_flag;
   } ansr_adv_t;

   typedef struct packed {
      ansr_fsm_t fsm;
      logic [1:0] strap_sync;
      logic [1:0] strap_age;
      logic strap_loaded;
      logic local_force;
      logic local_master;
      logic partner_force;
      logic partner_master;
      logic [1:0] resolution;
      logic exch_done;
      logic link_latched;
      logic restart_req;
      logic an_start;
      logic tech_en;
      logic role_master;
      logic cfg_fault;
      logic awready;
      logic wready;
      logic aw_held;
      logic w_held;
      logic [ADDR_W-1:0] awaddr;
      logic [15:0] wdata;
      logic [1:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } ansr_state_t;

   function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [15:0] idx);
      return addr == {idx, 2'b00};
   endfunction
endpackage

// ==== rtl/ansr_lfsr.sv ====
// Free-running random bit source for role tie breaks.
// Assumes one clock; seed is a plain nonzero constant.
`timescale 1ns/100ps
module ansr_lfsr (
   input wire logic clk_in,
   input wire logic arst_n_in,
   output logic rand_bit_out
);
   logic [15:0] lfsr_ff;
   logic [15:0] nxt_lfsr;

   // Maximal length taps, so the bit never sticks
   always_comb begin
      nxt_lfsr = {lfsr_ff[14:0],
                  lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         lfsr_ff <= ansr_pkg::LFSR_SEED;
      end else begin
         lfsr_ff <= nxt_lfsr;
      end
   end

   assign rand_bit_out = lfsr_ff[0];
endmodule

// ==== rtl/ansr_resolver.sv ====
// Master/slave resolution from both advertisements.
// Purely combinational; caller registers the result.
`timescale 1ns/100ps
module ansr_resolver (
   input wire logic local_force_flag_in,
   input wire logic local_master_flag_in,
   input wire ansr_pkg::ansr_adv_t partner_adv_in,
   input wire logic rand_bit_in,
   output logic [1:0] resolution_out
);
   logic loc_master;

   always_comb begin
      loc_master = local_master_flag_in; // RQ7
      resolution_out = ansr_pkg::RES_NONE;
      if (local_force_flag_in == partner_adv_in.force_flag) begin
         if (local_master_flag_in == partner_adv_in.master_flag) begin
            if (local_force_flag_in) begin
               resolution_out = ansr_pkg::RES_FAULT; // RQ8
            end else begin
               loc_master = rand_bit_in; // RQ5
            end
         end
      end else if (!local_force_flag_in) begin
         loc_master = !partner_adv_in.master_flag; // RQ6
      end
      if (resolution_out != ansr_pkg::RES_FAULT) begin
         resolution_out = loc_master ? ansr_pkg::RES_MASTER :
                                       ansr_pkg::RES_SLAVE; // RQ16
      end
   end
endmodule

// ==== rtl/ansr_top.sv ====
// Negotiation control, role resolution and AXI4-Lite registers.
// Assumes exchange and link inputs come from logic on the same clock;
// only the role strap pin is asynchronous.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/100ps
module ansr_top (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic role_strap_pin_in,
   input wire logic partner_page_valid_in,
   input wire ansr_pkg::ansr_adv_t partner_adv_in,
   input wire logic link_up_in,
   output logic an_start_out,
   output logic tech_enable_out,
   output logic role_master_out,
   output logic config_fault_out,
   input wire logic awvalid_in,
   input wire logic [ansr_pkg::ADDR_W-1:0] awaddr_in,
   output logic awready_out,
   input wire logic wvalid_in,
   input wire logic [ansr_pkg::DATA_W-1:0] wdata_in,
   input wire logic [3:0] wstrb_in,
   output logic wready_out,
   output logic bvalid_out,
   output logic [1:0] bresp_out,
   input wire logic bready_in,
   input wire logic arvalid_in,
   input wire logic [ansr_pkg::ADDR_W-1:0] araddr_in,
   output logic arready_out,
   output logic rvalid_out,
   output logic [ansr_pkg::DATA_W-1:0] rdata_out,
   output logic [1:0] rresp_out,
   input wire logic rready_in
);
   ansr_pkg::ansr_state_t st_ff;
   ansr_pkg::ansr_state_t nxt_st;
   logic rand_bit;
   logic [1:0] res_code;
   logic link_ok;
   logic page_take;
   logic wr_apply;
   logic [ansr_pkg::DATA_W-1:0] rd_word;
   logic rd_hit;

   ansr_lfsr u_lfsr (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .rand_bit_out(rand_bit)
   );

   ansr_resolver u_resolver (
      .local_force_flag_in(st_ff.local_force),
      .local_master_flag_in(st_ff.local_master),
      .partner_adv_in(partner_adv_in),
      .rand_bit_in(rand_bit),
      .resolution_out(res_code)
   );

   assign link_ok = (st_ff.fsm == ansr_pkg::AN_LINK_UP);
   assign page_take = (st_ff.fsm == ansr_pkg::AN_WAIT_PAGE) &&
                      partner_page_valid_in && !st_ff.restart_req;
   assign wr_apply = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;

   always_comb begin
      nxt_st = st_ff;
      rd_word = '0;
      rd_hit = 1'b0;
      nxt_st.an_start = 1'b0;

      // Strap passes two flops, then loads once
      nxt_st.strap_sync = {st_ff.strap_sync[0], role_strap_pin_in};
      if (!st_ff.strap_loaded) begin
         if (st_ff.strap_age == ansr_pkg::STRAP_SETTLE) begin
            nxt_st.strap_loaded = 1'b1;
            nxt_st.local_master = st_ff.strap_sync[1]; // RQ1
         end else begin
            nxt_st.strap_age = st_ff.strap_age + 2'h1;
         end
      end

      unique case (st_ff.fsm)
         ansr_pkg::AN_IDLE: begin
            if (st_ff.strap_loaded) begin
               nxt_st.fsm = ansr_pkg::AN_START;
            end
         end
         ansr_pkg::AN_START: begin
            nxt_st.an_start = 1'b1;
            nxt_st.exch_done = 1'b0;
            nxt_st.resolution = ansr_pkg::RES_NONE; // RQ16
            nxt_st.tech_en = 1'b0;
            nxt_st.cfg_fault = 1'b0;
            nxt_st.fsm = ansr_pkg::AN_WAIT_PAGE;
         end
         ansr_pkg::AN_WAIT_PAGE: begin
            if (partner_page_valid_in) begin
               nxt_st.partner_force = partner_adv_in.force_flag; // RQ4
               nxt_st.partner_master = partner_adv_in.master_flag; // RQ4
               nxt_st.resolution = res_code; // RQ9
               if (res_code == ansr_pkg::RES_FAULT) begin
                  nxt_st.cfg_fault = 1'b1; // RQ8
                  nxt_st.fsm = ansr_pkg::AN_FAULT;
               end else begin
                  nxt_st.exch_done = 1'b1; // RQ10
                  nxt_st.tech_en = 1'b1;
                  nxt_st.role_master = (res_code == ansr_pkg::RES_MASTER);
                  nxt_st.fsm = ansr_pkg::AN_LINK_WAIT;
               end
            end
         end
         ansr_pkg::AN_LINK_WAIT: begin
            if (link_up_in) begin
               nxt_st.fsm = ansr_pkg::AN_LINK_UP;
            end
         end
         ansr_pkg::AN_LINK_UP: begin
            if (!link_up_in) begin
               nxt_st.fsm = ansr_pkg::AN_START; // RQ13
            end
         end
         ansr_pkg::AN_FAULT: begin
            // Held with the link off until software restarts
            nxt_st.tech_en = 1'b0; // RQ8
         end
      endcase

      // Restart overrides any state but AN_IDLE; cleared when taken
      if (st_ff.restart_req && st_ff.fsm != ansr_pkg::AN_IDLE) begin
         nxt_st.fsm = ansr_pkg::AN_START; // RQ14
         nxt_st.restart_req = 1'b0; // RQ17
      end

      if (!link_ok) begin
         nxt_st.link_latched = 1'b0; // RQ12
      end

      // Write channel: address and data in either order
      if (awvalid_in && st_ff.awready) begin
         nxt_st.aw_held = 1'b1;
         nxt_st.awaddr = awaddr_in;
      end
      if (wvalid_in && st_ff.wready) begin
         nxt_st.w_held = 1'b1;
         nxt_st.wdata = wdata_in[15:0];
         nxt_st.wstrb = wstrb_in[1:0];
      end
      if (wr_apply) begin
         nxt_st.aw_held = 1'b0;
         nxt_st.w_held = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = ansr_pkg::RESP_OKAY;
         if (ansr_pkg::addr_hit(st_ff.awaddr, ansr_pkg::IDX_CONTROL)) begin
            // Placed after the clear so a new write is never lost
            if (st_ff.wstrb[ansr_pkg::LANE_HI] &&
                st_ff.wdata[ansr_pkg::BIT_RESTART]) begin
               nxt_st.restart_req = 1'b1; // RQ14
            end
         end else if (ansr_pkg::addr_hit(st_ff.awaddr,
                                         ansr_pkg::IDX_LOC_FORCE)) begin
            if (st_ff.wstrb[ansr_pkg::LANE_HI]) begin
               nxt_st.local_force = st_ff.wdata[ansr_pkg::BIT_FORCE]; // RQ2
            end
         end else if (ansr_pkg::addr_hit(st_ff.awaddr,
                                         ansr_pkg::IDX_LOC_ROLE)) begin
            if (st_ff.wstrb[ansr_pkg::LANE_LO]) begin
               nxt_st.local_master = st_ff.wdata[ansr_pkg::BIT_MASTER]; // RQ3
            end
         end else if (!(ansr_pkg::addr_hit(st_ff.awaddr,
                                           ansr_pkg::IDX_STATUS) ||
                        ansr_pkg::addr_hit(st_ff.awaddr,
                                           ansr_pkg::IDX_PART_FORCE) ||
                        ansr_pkg::addr_hit(st_ff.awaddr,
                                           ansr_pkg::IDX_PART_ROLE) ||
                        ansr_pkg::addr_hit(st_ff.awaddr,
                                           ansr_pkg::IDX_RESULT))) begin
            nxt_st.bresp = ansr_pkg::RESP_SLVERR;
         end
      end
      if (st_ff.bvalid && bready_in) begin
         nxt_st.bvalid = 1'b0;
      end
      nxt_st.awready = !nxt_st.aw_held && !nxt_st.bvalid;
      nxt_st.wready = !nxt_st.w_held && !nxt_st.bvalid;

      // Read decode
      if (ansr_pkg::addr_hit(araddr_in, ansr_pkg::IDX_CONTROL)) begin
         rd_hit = 1'b1;
         rd_word[ansr_pkg::BIT_RESTART] = st_ff.restart_req;
      end else if (ansr_pkg::addr_hit(araddr_in, ansr_pkg::IDX_STATUS)) begin
         rd_hit = 1'b1;
         rd_word[ansr_pkg::BIT_DONE_UP] = link_ok; // RQ11
         rd_word[ansr_pkg::BIT_LINK_LATCHED] = st_ff.link_latched; // RQ12
      end else if (ansr_pkg::addr_hit(araddr_in,
                                      ansr_pkg::IDX_LOC_FORCE)) begin
         rd_hit = 1'b1;
         rd_word[ansr_pkg::BIT_FORCE] = st_ff.local_force;
      end else if (ansr_pkg::addr_hit(araddr_in, ansr_pkg::IDX_LOC_ROLE)) begin
         rd_hit = 1'b1;
         rd_word[ansr_pkg::BIT_MASTER] = st_ff.local_master;
      end else if (ansr_pkg::addr_hit(araddr_in,
                                      ansr_pkg::IDX_PART_FORCE)) begin
         rd_hit = 1'b1;
         rd_word[ansr_pkg::BIT_FORCE] = st_ff.partner_force;
      end else if (ansr_pkg::addr_hit(araddr_in,
                                      ansr_pkg::IDX_PART_ROLE)) begin
         rd_hit = 1'b1;
         rd_word[ansr_pkg::BIT_MASTER] = st_ff.partner_master;
      end else if (ansr_pkg::addr_hit(araddr_in, ansr_pkg::IDX_RESULT)) begin
         rd_hit = 1'b1;
         rd_word[ansr_pkg::RES_MSB:ansr_pkg::RES_LSB] = st_ff.resolution;
         rd_word[ansr_pkg::BIT_EXCH_DONE] = st_ff.exch_done; // RQ10
      end

      if (arvalid_in && st_ff.arready) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rdata = rd_word;
         nxt_st.rresp = rd_hit ? ansr_pkg::RESP_OKAY : ansr_pkg::RESP_SLVERR;
         // Reading status re-arms the latch with the present state
         if (ansr_pkg::addr_hit(araddr_in, ansr_pkg::IDX_STATUS)) begin
            nxt_st.link_latched = link_ok; // RQ12
         end
      end else if (st_ff.rvalid && rready_in) begin
         nxt_st.rvalid = 1'b0;
      end
      nxt_st.arready = !nxt_st.rvalid;
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_ff <= '0;
         st_ff.fsm <= ansr_pkg::AN_IDLE;
         st_ff.awready <= 1'b1;
         st_ff.wready <= 1'b1;
         st_ff.arready <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign an_start_out = st_ff.an_start;
   assign tech_enable_out = st_ff.tech_en;
   assign role_master_out = st_ff.role_master;
   assign config_fault_out = st_ff.cfg_fault;
   assign awready_out = st_ff.awready;
   assign wready_out = st_ff.wready;
   assign bvalid_out = st_ff.bvalid;
   assign bresp_out = st_ff.bresp;
   assign arready_out = st_ff.arready;
   assign rvalid_out = st_ff.rvalid;
   assign rdata_out = st_ff.rdata;
   assign rresp_out = st_ff.rresp;

   property p_strap_load;
      @(posedge clk_in) disable iff (!arst_n_in)
      $rose(st_ff.strap_loaded) |-> st_ff.local_master == $past(st_ff.strap_sync[1]);
   endproperty
   a_strap_load: assert property (p_strap_load) // RQ1
      else $error("strap role not loaded");
   property p_force_write;
      @(posedge clk_in) disable iff (!arst_n_in)
      wr_apply && st_ff.wstrb[ansr_pkg::LANE_HI] &&
      ansr_pkg::addr_hit(st_ff.awaddr, ansr_pkg::IDX_LOC_FORCE) |=>
      st_ff.local_force == $past(st_ff.wdata[ansr_pkg::BIT_FORCE]) &&
      bvalid_out;
   endproperty
   a_force_write: assert property (p_force_write) // RQ2
      else $error("force advertisement not stored");
   property p_role_write;
      @(posedge clk_in) disable iff (!arst_n_in)
      wr_apply && st_ff.wstrb[ansr_pkg::LANE_LO] &&
      ansr_pkg::addr_hit(st_ff.awaddr, ansr_pkg::IDX_LOC_ROLE)
      |=> st_ff.local_master == $past(st_ff.wdata[ansr_pkg::BIT_MASTER]);
   endproperty
   a_role_write: assert property (p_role_write) // RQ3
      else $error("role advertisement not stored");
   property p_capture;
      @(posedge clk_in) disable iff (!arst_n_in)
      page_take |=> st_ff.partner_force == $past(partner_adv_in.force_flag)
         && st_ff.partner_master == $past(partner_adv_in.master_flag);
   endproperty
   a_capture: assert property (p_capture) // RQ4
      else $error("partner flags not captured");
   property p_random;
      @(posedge clk_in) disable iff (!arst_n_in)
      page_take && !st_ff.local_force && !partner_adv_in.force_flag &&
      st_ff.local_master == partner_adv_in.master_flag
      |=> role_master_out == $past(rand_bit);
   endproperty
   a_random: assert property (p_random) // RQ5
      else $error("tie not settled by random bit");
   property p_one_forced;
      @(posedge clk_in) disable iff (!arst_n_in)
      page_take && st_ff.local_force != partner_adv_in.force_flag
      |=> role_master_out == ($past(st_ff.local_force) ?
          $past(st_ff.local_master) : !$past(partner_adv_in.master_flag));
   endproperty
   a_one_forced: assert property (p_one_forced) // RQ6
      else $error("forced end lost priority");
   property p_own_role;
      @(posedge clk_in) disable iff (!arst_n_in)
      page_take && st_ff.local_force == partner_adv_in.force_flag &&
      st_ff.local_master != partner_adv_in.master_flag
      |=> role_master_out == $past(st_ff.local_master) && tech_enable_out;
   endproperty
   a_own_role: assert property (p_own_role) // RQ7
      else $error("own role not taken");
   property p_fault;
      @(posedge clk_in) disable iff (!arst_n_in)
      page_take && st_ff.local_force && partner_adv_in.force_flag &&
      st_ff.local_master == partner_adv_in.master_flag
      |=> config_fault_out && !tech_enable_out && !st_ff.exch_done
          ##1 !tech_enable_out;
   endproperty
   a_fault: assert property (p_fault) // RQ8
      else $error("config fault not flagged");
   property p_exch_done;
      @(posedge clk_in) disable iff (!arst_n_in)
      st_ff.fsm == ansr_pkg::AN_LINK_WAIT |-> st_ff.exch_done &&
         st_ff.resolution != ansr_pkg::RES_NONE && tech_enable_out;
   endproperty
   a_exch_done: assert property (p_exch_done) // RQ10
      else $error("exchange done not shown");
   property p_done_up_read;
      @(posedge clk_in) disable iff (!arst_n_in)
      arvalid_in && arready_out &&
      ansr_pkg::addr_hit(araddr_in, ansr_pkg::IDX_STATUS)
      |=> rvalid_out && rdata_out[ansr_pkg::BIT_DONE_UP] == $past(link_ok);
   endproperty
   a_done_up_read: assert property (p_done_up_read) // RQ11
      else $error("done and up bit wrong");
   property p_latch_low;
      @(posedge clk_in) disable iff (!arst_n_in)
      link_ok ##1 !link_ok |=> !st_ff.link_latched;
   endproperty
   a_latch_low: assert property (p_latch_low) // RQ12
      else $error("link status did not latch low");
   property p_auto_restart;
      @(posedge clk_in) disable iff (!arst_n_in)
      link_ok && !link_up_in && !st_ff.restart_req
      |=> st_ff.fsm == ansr_pkg::AN_START ##1 an_start_out;
   endproperty
   a_auto_restart: assert property (p_auto_restart) // RQ13
      else $error("no restart after link loss");
   property p_restart_set;
      @(posedge clk_in) disable iff (!arst_n_in)
      wr_apply && st_ff.wstrb[ansr_pkg::LANE_HI] &&
      st_ff.wdata[ansr_pkg::BIT_RESTART] &&
      ansr_pkg::addr_hit(st_ff.awaddr, ansr_pkg::IDX_CONTROL)
      |=> st_ff.restart_req;
   endproperty
   a_restart_set: assert property (p_restart_set) // RQ14
      else $error("restart write lost");
   property p_no_result;
      @(posedge clk_in) disable iff (!arst_n_in)
      st_ff.fsm == ansr_pkg::AN_START |=>
      st_ff.resolution == ansr_pkg::RES_NONE;
   endproperty
   a_no_result: assert property (p_no_result) // RQ16
      else $error("stale result kept");
   property p_restart_taken;
      @(posedge clk_in) disable iff (!arst_n_in)
      st_ff.restart_req && st_ff.fsm != ansr_pkg::AN_IDLE
      |=> st_ff.fsm == ansr_pkg::AN_START ##1 an_start_out;
   endproperty
   a_restart_taken: assert property (p_restart_taken) // RQ17
      else $error("restart not taken");
endmodule

// ==== bench/ansr_partner.sv ====
// Remote PHY model: one page per start, link follows tech enable.
// Assumes start pulse and tech enable come from clk_in logic.
`timescale 1ns/100ps
module ansr_partner (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic start_in,
   input wire logic tech_en_in,
   input wire logic drop_in,
   input wire logic [3:0] delay_in,
   input wire ansr_pkg::ansr_adv_t adv_in,
   output logic page_out,
   output ansr_pkg::ansr_adv_t adv_out,
   output logic link_out
);
   logic pend_ff;
   logic [3:0] cnt_ff;
   // Junk between pages, so stale sampling shows
   assign adv_out = page_out ? adv_in : ~adv_in;
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pend_ff <= 1'b0;
         cnt_ff <= 4'h0;
         page_out <= 1'b0;
         link_out <= 1'b0;
      end else begin
         page_out <= pend_ff && cnt_ff == 4'h0;
         if (start_in) begin
            pend_ff <= 1'b1;
            cnt_ff <= delay_in;
         end else if (pend_ff) begin
            pend_ff <= cnt_ff != 4'h0;
            cnt_ff <= cnt_ff - 4'h1;
         end
         link_out <= tech_en_in && !drop_in;
      end
   end
endmodule

// ==== bench/ansr_top_tb.sv ====
// Register-level bench for the role negotiation block.
// Assumes ansr_pkg and the remote PHY model.
`timescale 1ns/100ps
module ansr_top_tb;
   logic clk_in, arst_n_in, awvalid_in, wvalid_in, bready_in, arvalid_in;
   logic rready_in, awready_out, wready_out, bvalid_out, arready_out;
   logic rvalid_out, an_start_out, tech_enable_out, role_master_out;
   logic config_fault_out, partner_page_valid_in, link_up_in, drop;
   logic [ansr_pkg::ADDR_W-1:0] awaddr_in, araddr_in;
   logic [31:0] wdata_in, rdata_out, d;
   logic [3:0] wstrb_in, dly;
   logic [1:0] bresp_out, rresp_out, r, e;
   ansr_pkg::ansr_adv_t partner_adv_in, padv;
   int miscompares, tests_run, starts;
   // Strap left open: pull-down default
   ansr_top dut_u (.clk_in, .arst_n_in, .role_strap_pin_in(1'b0),
      .partner_page_valid_in, .partner_adv_in, .link_up_in, .an_start_out,
      .tech_enable_out, .role_master_out, .config_fault_out, .awvalid_in,
      .awaddr_in, .awready_out, .wvalid_in, .wdata_in, .wstrb_in,
      .wready_out, .bvalid_out, .bresp_out, .bready_in, .arvalid_in,
      .araddr_in, .arready_out, .rvalid_out, .rdata_out, .rresp_out,
      .rready_in);
   ansr_partner peer_u (.clk_in, .arst_n_in, .start_in(an_start_out),
      .tech_en_in(tech_enable_out), .drop_in(drop), .delay_in(dly),
      .adv_in(padv), .page_out(partner_page_valid_in),
      .adv_out(partner_adv_in), .link_out(link_up_in));
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   always @(posedge clk_in) if (an_start_out === 1'b1) starts++;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One bus transfer; called just after a rising edge
   task automatic xfer(input logic wr, input logic [15:0] idx,
                       input logic [31:0] v);
      logic a, w, b, ta, tw, tb;
      a = 1'b1;
      w = wr;
      b = 1'b1;
      if (wr) begin
         awaddr_in <= {idx, 2'b00};
         wdata_in <= v;
         awvalid_in <= 1'b1;
         wvalid_in <= 1'b1;
         bready_in <= 1'b1;
      end else begin
         araddr_in <= {idx, 2'b00};
         arvalid_in <= 1'b1;
         rready_in <= 1'b1;
      end
      while (b) begin
         @(negedge clk_in);
         ta = a && (wr ? awready_out : arready_out);
         tw = w && wready_out;
         tb = !a && !w && (wr ? bvalid_out : rvalid_out);
         d = rdata_out;
         r = wr ? bresp_out : rresp_out;
         @(posedge clk_in);
         if (ta) awvalid_in <= 1'b0;
         if (ta) arvalid_in <= 1'b0;
         if (tw) wvalid_in <= 1'b0;
         if (tb) bready_in <= 1'b0;
         if (tb) rready_in <= 1'b0;
         a = a && !ta;
         w = w && !tw;
         b = !tb;
      end
      // Idle edge, so the next call never re-drives a ready in one step
      @(posedge clk_in);
   endtask
   task automatic rdchk(input logic [15:0] idx, input logic [31:0] m, x);
      xfer(1'b0, idx, 32'h0);
      chk(d & m, x);
   endtask
   // New start seen, then link up or fault settled
   task automatic settle(input int n);
      while (starts == n) @(posedge clk_in);
      drop <= 1'b0;
      while (!(tech_enable_out && link_up_in) && !config_fault_out)
         @(posedge clk_in);
      repeat (10) @(posedge clk_in);
   endtask
   function automatic logic [1:0] res(input logic lf, lm, rf, rm);
      logic mst;
      mst = (lf != rf) ? (lf ? lm : !rm) : lm;
      if (lf && rf && lm == rm) return ansr_pkg::RES_FAULT;
      if (!lf && !rf && lm == rm) return ansr_pkg::RES_NONE;
      return mst ? ansr_pkg::RES_MASTER : ansr_pkg::RES_SLAVE;
   endfunction
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Whole run needs under a thousand cycles
   initial begin
      #400000;
      miscompares++;
      wrap_up();
   end
   initial begin
      int n;
      {awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in} = '0;
      awaddr_in = '0;
      araddr_in = '0;
      wdata_in = '0;
      wstrb_in = 4'hf;
      {drop, dly, padv} = 7'h0d;
      {arst_n_in, miscompares, tests_run, starts} = '0;
      repeat (8) @(posedge clk_in);
      arst_n_in <= 1'b1;
      settle(0);
      rdchk(ansr_pkg::IDX_LOC_ROLE, 32'h10, 32'h0);
      rdchk(ansr_pkg::IDX_RESULT, 32'h61, 32'h21);
      rdchk(ansr_pkg::IDX_PART_ROLE, 32'h10, 32'h10);
      rdchk(ansr_pkg::IDX_PART_FORCE, 32'h1000, 32'h0);
      rdchk(ansr_pkg::IDX_STATUS, 32'h24, 32'h20);
      rdchk(ansr_pkg::IDX_STATUS, 32'h24, 32'h24);
      xfer(1'b0, 16'h0204, 32'h0);
      chk({d[29:0], r}, {30'h0, ansr_pkg::RESP_SLVERR});
      xfer(1'b1, 16'h0204, 32'hffff);
      chk({30'h0, r}, {30'h0, ansr_pkg::RESP_SLVERR});
      n = starts;
      drop <= 1'b1;
      settle(n);
      rdchk(ansr_pkg::IDX_STATUS, 32'h24, 32'h20);
      rdchk(ansr_pkg::IDX_STATUS, 32'h24, 32'h24);
      for (int i = 0; i < 16; i++) begin
         padv <= i[1:0];
         dly <= i[0] ? 4'h1 : 4'hc;
         xfer(1'b1, ansr_pkg::IDX_LOC_FORCE, {19'h0, i[3], 12'h0});
         xfer(1'b1, ansr_pkg::IDX_LOC_ROLE, {27'h0, i[2], 4'h0});
         rdchk(ansr_pkg::IDX_LOC_FORCE, 32'h1000, {19'h0, i[3], 12'h0});
         rdchk(ansr_pkg::IDX_LOC_ROLE, 32'h10, {27'h0, i[2], 4'h0});
         n = starts;
         xfer(1'b1, ansr_pkg::IDX_CONTROL, 32'h200);
         settle(n);
         rdchk(ansr_pkg::IDX_CONTROL, 32'h200, 32'h0);
         xfer(1'b0, ansr_pkg::IDX_RESULT, 32'h0);
         e = res(i[3], i[2], i[1], i[0]);
         if (e == ansr_pkg::RES_NONE) begin
            chk({31'h0, d[6:5] inside {2'h1, 2'h2}}, 32'h1);
            e = d[6:5];
         end
         chk({30'h0, d[6:5]}, {30'h0, e});
         // Role output only means something while tech enable is high
         chk({29'h0, role_master_out & tech_enable_out, config_fault_out,
            tech_enable_out}, {29'h0, e == ansr_pkg::RES_MASTER,
            e == ansr_pkg::RES_FAULT, e != ansr_pkg::RES_FAULT});
      end
      wrap_up();
   end
endmodule
